// ---- hdl/pmf_top.sv ----
// port mirror filter: port mask, address match and divider stages with apb registers
//
// Register access over APB and the address map are this design's own decisions.
`include "pmf_map.svh"
`timescale 1ns/10ps
`default_nettype none
module pmf_top #(
    parameter int DIV_W = 10
) (
    input  wire logic              REF_CLK,      // core clock, 25 mhz
    input  wire logic              RSTN,         // synchronous reset, active low
    input  wire logic              PSEL,         // apb select
    input  wire logic              PENABLE,      // apb access phase
    input  wire logic              PWRITE,       // apb write
    input  wire logic [11:0]       PADDR,        // apb byte address
    input  wire logic [31:0]       PWDATA,       // apb write data
    output logic      [31:0]       PRDATA,       // apb read data
    output logic                   PREADY,       // apb ready
    output logic                   PSLVERR,      // apb error, unmapped address
    input  wire logic              RX_VALID,     // received frame descriptor valid
    input  wire pmf_pkg::pmf_desc_s RX_DESC,     // received frame port and addresses
    input  wire pmf_pkg::pmf_map_t RX_FWD_MAP,   // normal forwarding map of received frame
    output logic                   RX_OUT_VALID, // received frame decision valid
    output pmf_pkg::pmf_map_t      RX_OUT_MAP,   // forwarding map, unchanged
    output pmf_pkg::pmf_map_t      RX_MIR_MAP,   // capture port copy map
    input  wire logic              TX_VALID,     // transmitted frame descriptor valid
    input  wire pmf_pkg::pmf_desc_s TX_DESC,     // transmitted frame port and addresses
    output logic                   TX_OUT_VALID, // transmitted frame decision valid
    output pmf_pkg::pmf_map_t      TX_MIR_MAP    // capture port copy map
);
    logic                         mir_en_r;
    logic [pmf_pkg::PORT_W-1:0]   cap_r;
    pmf_pkg::pmf_map_t            mask_r [2];
    logic [1:0]                   fsel_r [2];
    logic                         den_r  [2];
    logic [DIV_W-1:0]             div_r  [2];
    logic [47:0]                  mac_r  [2];
    logic [DIV_W-1:0]             cnt_r  [2];
    logic                         vld    [2];
    pmf_pkg::pmf_desc_s           desc   [2];
    logic                         pass   [2];
    logic                         keep   [2];
    pmf_pkg::pmf_map_t            cap_map;
    logic                         wr_en;
    logic [31:0]                  rd_nxt;
    logic                         hit;

    assign vld[0]  = RX_VALID;
    assign vld[1]  = TX_VALID;
    assign desc[0] = RX_DESC;
    assign desc[1] = TX_DESC;
    assign cap_map = pmf_pkg::pmf_map_t'(1) << cap_r;

    // apb: setup cycle prepares the answer, first access cycle completes it
    assign wr_en = PSEL && PENABLE && PREADY && PWRITE;

    always_comb
    begin
        hit    = 1'b1;
        rd_nxt = 32'h0;
        unique case (PADDR)
            `PMF_OFS_CAP_CTRL:  rd_nxt = {21'h0, cap_r, 7'h0, mir_en_r};
            `PMF_OFS_IN_CTRL:   rd_nxt = {21'h0, den_r[0], fsel_r[0], mask_r[0]};
            `PMF_OFS_IN_DIV:    rd_nxt = 32'(div_r[0]);
            `PMF_OFS_IN_MAC_L:  rd_nxt = mac_r[0][31:0];
            `PMF_OFS_IN_MAC_H:  rd_nxt = {16'h0, mac_r[0][47:32]};
            `PMF_OFS_OUT_CTRL:  rd_nxt = {21'h0, den_r[1], fsel_r[1], mask_r[1]};
            `PMF_OFS_OUT_DIV:   rd_nxt = 32'(div_r[1]);
            `PMF_OFS_OUT_MAC_L: rd_nxt = mac_r[1][31:0];
            `PMF_OFS_OUT_MAC_H: rd_nxt = {16'h0, mac_r[1][47:32]};
            `PMF_OFS_STATUS:    rd_nxt = {6'h0, cnt_r[1], 6'h0, cnt_r[0]};
            default:            hit    = 1'b0;
        endcase
    end

    always_ff @(posedge REF_CLK)
    begin
        if (!RSTN)
        begin
            PREADY  <= 1'b0;
            PSLVERR <= 1'b0;
            PRDATA  <= `PMF_RST_WORD;
        end
        else
        begin
            PREADY  <= PSEL && !PENABLE;
            PSLVERR <= PSEL && !PENABLE && !hit;
            if (PSEL && !PENABLE)
                PRDATA <= PWRITE ? 32'h0 : rd_nxt;
        end
    end

    always_ff @(posedge REF_CLK)
    begin
        if (!RSTN)
        begin
            mir_en_r <= 1'b0;
            cap_r    <= '0;
        end
        else if (wr_en && PADDR == `PMF_OFS_CAP_CTRL)
        begin
            mir_en_r <= PWDATA[`PMF_BIT_MIR_EN];
            cap_r    <= PWDATA[`PMF_CAP_LSB +: pmf_pkg::PORT_W];
        end
    end

    // one filter chain per direction: 0 is ingress, 1 is egress
    for (genvar d = 0; d < 2; d++)
    begin : g_dir
        localparam logic [11:0] OFS_CTRL = (d == 0) ? `PMF_OFS_IN_CTRL : `PMF_OFS_OUT_CTRL;
        localparam logic [11:0] OFS_DIV  = (d == 0) ? `PMF_OFS_IN_DIV : `PMF_OFS_OUT_DIV;
        localparam logic [11:0] OFS_ML   = (d == 0) ? `PMF_OFS_IN_MAC_L : `PMF_OFS_OUT_MAC_L;
        localparam logic [11:0] OFS_MH   = (d == 0) ? `PMF_OFS_IN_MAC_H : `PMF_OFS_OUT_MAC_H;
        logic addr_ok;

        always_comb
        begin
            unique case (fsel_r[d])
                `PMF_FSEL_DA: addr_ok = (desc[d].da == mac_r[d]);
                `PMF_FSEL_SA: addr_ok = (desc[d].sa == mac_r[d]);
                default:      addr_ok = 1'b1;
            endcase
        end

        // mask first, then address; divider only sees survivors of both
        assign pass[d] = vld[d] && mir_en_r && mask_r[d][desc[d].port] && addr_ok;
        // a divisor lowered below the running count still closes the cycle
        assign keep[d] = pass[d] && (!den_r[d] || cnt_r[d] >= div_r[d]);

        always_ff @(posedge REF_CLK)
        begin
            if (!RSTN)
            begin
                mask_r[d] <= '0;
                fsel_r[d] <= `PMF_FSEL_ALL;
                den_r[d]  <= 1'b0;
            end
            else if (wr_en && PADDR == OFS_CTRL)
            begin
                mask_r[d] <= PWDATA[`PMF_MASK_LSB +: pmf_pkg::NPORT];
                fsel_r[d] <= PWDATA[`PMF_FSEL_LSB +: 2];
                den_r[d]  <= PWDATA[`PMF_DEN_BIT];
            end
        end

        always_ff @(posedge REF_CLK)
        begin
            if (!RSTN)
                div_r[d] <= '0;
            else if (wr_en && PADDR == OFS_DIV)
                div_r[d] <= PWDATA[DIV_W-1:0];
        end

        always_ff @(posedge REF_CLK)
        begin
            if (!RSTN)
                mac_r[d] <= 48'h0;
            else if (wr_en && PADDR == OFS_ML)
                mac_r[d][31:0] <= PWDATA;
            else if (wr_en && PADDR == OFS_MH)
                mac_r[d][47:32] <= PWDATA[15:0];
        end

        // one shared count per direction, whatever port the frame came from
        always_ff @(posedge REF_CLK)
        begin
            if (!RSTN || !den_r[d])
                cnt_r[d] <= '0;
            else if (keep[d])
                cnt_r[d] <= '0;
            else if (pass[d])
                cnt_r[d] <= cnt_r[d] + DIV_W'(1);
        end
    end

    always_ff @(posedge REF_CLK)
    begin
        if (!RSTN)
        begin
            RX_OUT_VALID <= 1'b0;
            RX_OUT_MAP   <= '0;
            RX_MIR_MAP   <= '0;
            TX_OUT_VALID <= 1'b0;
            TX_MIR_MAP   <= '0;
        end
        else
        begin
            RX_OUT_VALID <= RX_VALID;
            RX_OUT_MAP   <= RX_VALID ? RX_FWD_MAP : '0;
            RX_MIR_MAP   <= keep[0] ? cap_map : '0;
            TX_OUT_VALID <= TX_VALID;
            TX_MIR_MAP   <= keep[1] ? cap_map : '0;
        end
    end

    default clocking cb @(posedge REF_CLK); endclocking
    default disable iff (!RSTN);

    global_enable_a: assert property (!mir_en_r |=> RX_MIR_MAP == '0 && TX_MIR_MAP == '0)
        else $error("mirror copy while mirroring disabled");
    capture_port_a: assert property (keep[0] |=> RX_MIR_MAP == (pmf_pkg::pmf_map_t'(1) << $past(cap_r)))
        else $error("mirror copy not on capture port");
    rx_mask_a: assert property (RX_VALID && !mask_r[0][RX_DESC.port] |=> RX_MIR_MAP == '0)
        else $error("unmonitored ingress port mirrored");
    tx_mask_a: assert property (TX_VALID && !mask_r[1][TX_DESC.port] |=> TX_MIR_MAP == '0)
        else $error("unmonitored egress port mirrored");
    rx_addr_match_a: assert property (keep[0] && fsel_r[0] == `PMF_FSEL_SA |-> RX_DESC.sa == mac_r[0])
        else $error("ingress source filter mismatch");
    tx_addr_match_a: assert property (keep[1] && fsel_r[1] == `PMF_FSEL_DA |-> TX_DESC.da == mac_r[1])
        else $error("egress destination filter mismatch");
    divider_wrap_a: assert property (pass[0] && den_r[0] && cnt_r[0] < div_r[0] |=> RX_MIR_MAP == '0)
        else $error("ingress divider kept early frame");
    shared_count_a: assert property (pass[0] && !keep[0] && den_r[0] |=> cnt_r[0] == $past(cnt_r[0]) + 1'b1)
        else $error("ingress divider count not advanced");
    tx_divider_a: assert property (pass[1] && den_r[1] && cnt_r[1] >= div_r[1] |=> TX_MIR_MAP != '0)
        else $error("egress divider lost nth frame");
    no_sampling_a: assert property (pass[0] && !den_r[0] |=> RX_MIR_MAP != '0)
        else $error("frame dropped with divider off");
    fwd_intact_a: assert property (RX_VALID |=> RX_OUT_MAP == $past(RX_FWD_MAP) && RX_OUT_VALID)
        else $error("forwarding map altered");

    // apb side: one access cycle, error and zero data only together with ready
    ready_after_setup_a: assert property (PSEL && !PENABLE |=> PREADY)
        else $error("no ready after setup cycle");
    ready_pulse_a: assert property (PREADY |=> !PREADY)
        else $error("ready held beyond one access cycle");
    error_with_ready_a: assert property (PSLVERR |-> PREADY)
        else $error("error raised without ready");
    error_data_a: assert property (PSLVERR |-> PRDATA == 32'h0)
        else $error("unmapped access returned data");
    write_data_a: assert property (PSEL && !PENABLE && PWRITE |=> PRDATA == 32'h0)
        else $error("write returned read data");
    enable_write_a: assert property (wr_en && PADDR == `PMF_OFS_CAP_CTRL |=>
        mir_en_r == $past(PWDATA[`PMF_BIT_MIR_EN]))
        else $error("mirror enable write lost");
    cap_write_a: assert property (wr_en && PADDR == `PMF_OFS_CAP_CTRL |=>
        cap_r == $past(PWDATA[`PMF_CAP_LSB +: pmf_pkg::PORT_W]))
        else $error("capture port write lost");
    in_mask_write_a: assert property (wr_en && PADDR == `PMF_OFS_IN_CTRL |=>
        mask_r[0] == $past(PWDATA[`PMF_MASK_LSB +: pmf_pkg::NPORT]))
        else $error("ingress mask write lost");
    out_mask_write_a: assert property (wr_en && PADDR == `PMF_OFS_OUT_CTRL |=>
        mask_r[1] == $past(PWDATA[`PMF_MASK_LSB +: pmf_pkg::NPORT]))
        else $error("egress mask write lost");
    unmapped_write_a: assert property (wr_en && !hit |=> $stable(mir_en_r) && $stable(cap_r) && $stable(den_r[0])
        && $stable(den_r[1]))
        else $error("unmapped write changed a register");
    status_count_a: assert property (PSEL && !PENABLE && !PWRITE && PADDR == `PMF_OFS_STATUS |=>
        PRDATA[DIV_W-1:0] == $past(cnt_r[0]))
        else $error("status does not show ingress count");

    // ingress chain
    rx_idle_a: assert property (!RX_VALID |=> !RX_OUT_VALID && RX_OUT_MAP == '0 && RX_MIR_MAP == '0)
        else $error("ingress output without frame");
    rx_onehot_a: assert property ($onehot0(RX_MIR_MAP))
        else $error("ingress copy on more than one port");
    rx_da_match_a: assert property (keep[0] && fsel_r[0] == `PMF_FSEL_DA |-> RX_DESC.da == mac_r[0])
        else $error("ingress destination filter mismatch");
    rx_mask_pass_a: assert property (RX_VALID && mir_en_r && mask_r[0][RX_DESC.port] &&
        fsel_r[0] == `PMF_FSEL_ALL && !den_r[0] |=> RX_MIR_MAP != '0)
        else $error("monitored ingress frame not mirrored");
    rx_nth_frame_a: assert property (pass[0] && den_r[0] && cnt_r[0] >= div_r[0] |=> RX_MIR_MAP != '0)
        else $error("ingress divider lost nth frame");
    rx_kept_clear_a: assert property (keep[0] && den_r[0] |=> cnt_r[0] == '0)
        else $error("ingress count not restarted");
    rx_count_clear_a: assert property (!den_r[0] |=> cnt_r[0] == '0)
        else $error("ingress count running with divider off");

    // egress chain
    tx_capture_a: assert property (keep[1] |=> TX_MIR_MAP == (pmf_pkg::pmf_map_t'(1) << $past(cap_r)))
        else $error("egress copy not on capture port");
    tx_onehot_a: assert property ($onehot0(TX_MIR_MAP))
        else $error("egress copy on more than one port");
    tx_idle_a: assert property (!TX_VALID |=> !TX_OUT_VALID && TX_MIR_MAP == '0)
        else $error("egress output without frame");
    tx_valid_a: assert property (TX_VALID |=> TX_OUT_VALID)
        else $error("egress decision missing");
    tx_sa_match_a: assert property (keep[1] && fsel_r[1] == `PMF_FSEL_SA |-> TX_DESC.sa == mac_r[1])
        else $error("egress source filter mismatch");
    tx_mask_pass_a: assert property (TX_VALID && mir_en_r && mask_r[1][TX_DESC.port] &&
        fsel_r[1] == `PMF_FSEL_ALL && !den_r[1] |=> TX_MIR_MAP != '0)
        else $error("monitored egress frame not mirrored");
    tx_wrap_a: assert property (pass[1] && den_r[1] && cnt_r[1] < div_r[1] |=> TX_MIR_MAP == '0)
        else $error("egress divider kept early frame");
    tx_count_a: assert property (pass[1] && !keep[1] && den_r[1] |=> cnt_r[1] == $past(cnt_r[1]) + 1'b1)
        else $error("egress divider count not advanced");
    tx_no_sampling_a: assert property (pass[1] && !den_r[1] |=> TX_MIR_MAP != '0)
        else $error("egress frame dropped with divider off");

    rx_sampled_c: cover property (den_r[0] && div_r[0] > 1 && keep[0]);
    tx_sa_match_c: cover property (keep[1] && fsel_r[1] == `PMF_FSEL_SA);
    both_dirs_c: cover property (keep[0] && keep[1]);
    rx_da_filter_c: cover property (keep[0] && fsel_r[0] == `PMF_FSEL_DA);
    apb_error_c: cover property (PSLVERR);
endmodule : pmf_top
`default_nettype wire

// ---- hdl/pmf_map.svh ----
// register offsets, field positions and reset values of the port mirror filter
`ifndef PMF_MAP_SVH
`define PMF_MAP_SVH
`define PMF_OFS_CAP_CTRL  12'h000
`define PMF_OFS_IN_CTRL   12'h004
`define PMF_OFS_IN_DIV    12'h008
`define PMF_OFS_IN_MAC_L  12'h00c
`define PMF_OFS_IN_MAC_H  12'h010
`define PMF_OFS_OUT_CTRL  12'h014
`define PMF_OFS_OUT_DIV   12'h018
`define PMF_OFS_OUT_MAC_L 12'h01c
`define PMF_OFS_OUT_MAC_H 12'h020
`define PMF_OFS_STATUS    12'h024
`define PMF_BIT_MIR_EN    0
`define PMF_CAP_LSB       8
`define PMF_MASK_LSB      0
`define PMF_FSEL_LSB      8
`define PMF_DEN_BIT       10
`define PMF_STAT_OUT_LSB  16
`define PMF_FSEL_ALL      2'h0
`define PMF_FSEL_DA       2'h1
`define PMF_FSEL_SA       2'h2
`define PMF_RST_WORD      32'h0000_0000
`endif

// ---- hdl/pmf_pkg.sv ----
// types shared by the port mirror filter
package pmf_pkg;
    localparam int PORT_W = 3;
    localparam int NPORT  = 8;
    typedef logic [NPORT-1:0] pmf_map_t;
    typedef struct packed {
        logic [PORT_W-1:0] port;
        logic [47:0]       da;
        logic [47:0]       sa;
    } pmf_desc_s;
endpackage : pmf_pkg

// ---- dv/pmf_fwd_model.sv ----
// frame source standing in for the forwarding pipeline and port macs
`timescale 1ns/10ps
`default_nettype none
module pmf_fwd_model (
    input  wire logic          clk,      // core clock
    output logic               rx_valid, // rx descriptor strobe
    output pmf_pkg::pmf_desc_s rx_desc,  // rx port and addresses
    output pmf_pkg::pmf_map_t  rx_map,   // rx forwarding map
    output logic               tx_valid, // tx descriptor strobe
    output pmf_pkg::pmf_desc_s tx_desc   // tx port and addresses
);
    initial
    begin
        rx_valid = 1'b0;
        tx_valid = 1'b0;
        rx_desc  = '0;
        tx_desc  = '0;
        rx_map   = '0;
    end

    task automatic send(input logic tx, input logic [2:0] p, input logic [47:0] da, input logic [47:0] sa,
                        input logic [7:0] m);
        @(posedge clk);
        if (tx)
        begin
            tx_valid <= 1'b1;
            tx_desc  <= {p, da, sa};
        end
        else
        begin
            rx_valid <= 1'b1;
            rx_desc  <= {p, da, sa};
            rx_map   <= m;
        end
        @(posedge clk);
        rx_valid <= 1'b0;
        tx_valid <= 1'b0;
        // lines go stale once the strobe drops, so show a different pattern
        rx_desc  <= ~rx_desc;
        tx_desc  <= ~tx_desc;
        rx_map   <= ~rx_map;
    endtask : send
endmodule : pmf_fwd_model
`default_nettype wire

// ---- dv/testbench.sv ----
// self-checking bench for the port mirror filter
`include "pmf_map.svh"
`timescale 1ns/10ps
`default_nettype none
module testbench;
    logic               clk;
    logic               rstn;
    logic               psel;
    logic               penable;
    logic               pwrite;
    logic [11:0]        paddr;
    logic [31:0]        pwdata;
    logic [31:0]        prdata;
    logic               pready;
    logic               pslverr;
    logic               rx_valid;
    logic               tx_valid;
    logic               rx_ov;
    logic               tx_ov;
    pmf_pkg::pmf_desc_s rx_desc;
    pmf_pkg::pmf_desc_s tx_desc;
    pmf_pkg::pmf_map_t  rx_map;
    pmf_pkg::pmf_map_t  rx_omap;
    pmf_pkg::pmf_map_t  rx_mir;
    pmf_pkg::pmf_map_t  tx_mir;
    int                 n_errors;
    int                 tests_run;
    logic [31:0]        q;
    logic [47:0]        m;

    pmf_top #(.DIV_W(10)) dut_u (.REF_CLK(clk), .RSTN(rstn), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
        .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
        .RX_VALID(rx_valid), .RX_DESC(rx_desc), .RX_FWD_MAP(rx_map), .RX_OUT_VALID(rx_ov),
        .RX_OUT_MAP(rx_omap), .RX_MIR_MAP(rx_mir), .TX_VALID(tx_valid), .TX_DESC(tx_desc),
        .TX_OUT_VALID(tx_ov), .TX_MIR_MAP(tx_mir));
    pmf_fwd_model part_u (.clk(clk), .rx_valid(rx_valid), .rx_desc(rx_desc), .rx_map(rx_map),
        .tx_valid(tx_valid), .tx_desc(tx_desc));

    initial
    begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    task automatic complete_run();
        $display("comparisons %0d mismatches %0d", tests_run, n_errors);
        if (n_errors == 0 && tests_run > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : complete_run

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp)
        begin
            n_errors++;
            $display("[ERR] t=%0t got %h exp %h", $time, got, exp);
        end
    endtask : chk

    // one apb transfer; request held until pready is seen at an edge
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic err);
        int n;
        n = 0;
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1 && n < 16)
        begin
            @(posedge clk);
            n++;
        end
        q = prdata;
        chk({30'h0, pready, pslverr}, {30'h0, 1'b1, err});
        psel    <= 1'b0;
        penable <= 1'b0;
        // one idle edge between transfers so psel is never driven twice in one step
        @(posedge clk);
    endtask : apb

    task automatic rd(input logic [11:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0, 1'b0);
        chk(q, exp);
    endtask : rd

    task automatic frm(input logic tx, input logic [2:0] p, input logic [47:0] da, input logic [47:0] sa,
                       input logic [7:0] exp);
        part_u.send(tx, p, da, sa, {5'h0, p} ^ 8'ha5);
        #1;
        chk({23'h0, tx ? tx_ov : rx_ov, tx ? tx_mir : rx_mir}, {23'h0, 1'b1, exp});
        if (!tx)
            chk({24'h0, rx_omap}, {24'h0, {5'h0, p} ^ 8'ha5});
        @(posedge clk);
    endtask : frm

    initial
    begin
        #2000000;
        n_errors++;
        complete_run();
    end

    initial
    begin
        rstn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
        n_errors = 0;
        tests_run = 0;
        repeat (3) @(posedge clk);
        rstn <= 1'b1;
        @(posedge clk);
        for (int i = 0; i < 10; i++)
            rd(12'(4 * i), `PMF_RST_WORD);
        apb(1'b0, 12'h028, 32'h0, 1'b1);
        chk(q, 32'h0);
        apb(1'b1, 12'h028, 32'hffff_ffff, 1'b1);
        apb(1'b1, `PMF_OFS_STATUS, 32'hffff_ffff, 1'b0);
        rd(`PMF_OFS_STATUS, 32'h0);
        apb(1'b1, `PMF_OFS_CAP_CTRL, 32'hffff_ffff, 1'b0);
        rd(`PMF_OFS_CAP_CTRL, 32'h0000_0701);
        apb(1'b1, `PMF_OFS_CAP_CTRL, 32'h0000_0500, 1'b0);
        apb(1'b1, `PMF_OFS_IN_CTRL, 32'h0000_00ff, 1'b0);
        frm(1'b0, 3'h2, 48'h1, 48'h2, 8'h00);
        apb(1'b1, `PMF_OFS_CAP_CTRL, 32'h0000_0501, 1'b0);
        for (int s = 0; s < 2; s++)
        begin
            m = s ? 48'h75c3_ae1d_64f8 : 48'h8a3c_51e2_9b07;
            apb(1'b1, `PMF_OFS_IN_MAC_L + 12'(16 * s), m[31:0], 1'b0);
            apb(1'b1, `PMF_OFS_IN_MAC_H + 12'(16 * s), {16'h0, m[47:32]}, 1'b0);
            rd(`PMF_OFS_IN_MAC_H + 12'(16 * s), {16'h0, m[47:32]});
            // filter code 3 decodes as mirror all
            for (int f = 0; f < 4; f++)
            begin
                apb(1'b1, `PMF_OFS_IN_CTRL + 12'(16 * s), {22'h0, 2'(f), 8'h04}, 1'b0);
                frm(1'(s), 3'h3, m, m, 8'h00);
                frm(1'(s), 3'h2, m, 48'h0, (f != 2) ? 8'h20 : 8'h00);
                frm(1'(s), 3'h2, 48'h0, m, (f != 1) ? 8'h20 : 8'h00);
                frm(1'(s), 3'h2, m ^ 48'h8000_0000_0000, m ^ 48'h1, (f % 3 == 0) ? 8'h20 : 8'h00);
            end
            // divisor differs per side so a shared divider shows up
            apb(1'b1, `PMF_OFS_IN_DIV + 12'(16 * s), 32'(2 - s), 1'b0);
            apb(1'b1, `PMF_OFS_IN_CTRL + 12'(16 * s), 32'h0000_0403, 1'b0);
            rd(`PMF_OFS_IN_CTRL + 12'(16 * s), 32'h0000_0403);
            rd(`PMF_OFS_IN_DIV + 12'(16 * s), 32'(2 - s));
            for (int k = 0; k < 6; k++)
            begin
                if (k == 1)
                    frm(1'(s), 3'h2, m, m, 8'h00);
                frm(1'(s), 3'(k % 2), m, m, (k % (3 - s) == 2 - s) ? 8'h20 : 8'h00);
            end
            apb(1'b1, `PMF_OFS_IN_CTRL + 12'(16 * s), 32'h0000_0003, 1'b0);
            frm(1'(s), 3'h0, m, m, 8'h20);
            frm(1'(s), 3'h1, m, m, 8'h20);
        end
        complete_run();
    end
endmodule : testbench
`default_nettype wire
